/* File: hdl/led_sink_consts.vh */
// Offsets, field positions, reset values and timing figures for the
// channel four/five sink registers and the grouped fade timer.
// Assumed to be included by the sink configuration modules only.
`ifndef LED_SINK_CONSTS_VH
`define LED_SINK_CONSTS_VH

`define CH4_SINK_CONFIG_OFS 8'h2b
`define CH5_SINK_CONFIG_OFS 8'h2c
`define GROUP_FADE_TIMING_OFS 8'h2d

`define GROUP_SELECT_BIT 7
`define UNUSED_BIT 6
`define CODE_MSB 5
`define CODE_LSB 0
`define FADE_OUT_MSB 7
`define FADE_OUT_LSB 4
`define FADE_IN_MSB 3
`define FADE_IN_LSB 0

`define GROUP_SELECT_RST 1'h0
`define CURRENT_CODE_RST 6'h00
`define FADE_TIME_RST 4'h0
`define UNMAPPED_READ 8'h00

`define FADE_UNIT_MS 300
`define CLK_FREQ_MHZ 100
`define FADE_LEVEL_STEPS 63

`endif

/* File: hdl/sink_level_map.v */
// Square-law map from a 6-bit current code to a sink level.
// Assumes the code comes from logic on the same clock.
`timescale 1ns/1ns
`include "led_sink_consts.vh"

module sink_level_map (
   input wire clk_in,          // System clock
   input wire rst_in,          // Asynchronous reset, active high
   input wire [5:0] code_in,   // Current code
   output reg [11:0] level_out // Level in units of full scale / 3969
);

   // Code squared: 63 gives 3969, i.e. full 20 mA
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         level_out <= 12'h000;
      end else begin
         level_out <= {6'h00, code_in} * {6'h00, code_in};
      end
   end

endmodule // sink_level_map

/* File: hdl/led_sink_config_fade_timer.v */
// Sink configuration registers for channels four and five and the
// grouped backlight fade timer, with fade ramp and square-law levels.
// Assumes the serial interface engine presents decoded register
// accesses on this clock, and the grouped code comes from logic on this clock.
`timescale 1ns/1ns
`include "led_sink_consts.vh"

module led_sink_config_fade_timer #(
   // Cycles per ramp step for each fade code unit; shorten in simulation
   parameter STEP_UNIT_CYCLES = (`FADE_UNIT_MS * `CLK_FREQ_MHZ * 1000) / `FADE_LEVEL_STEPS
) (
   input wire clk_in,                   // System clock, 100 MHz
   input wire rst_in,                   // Asynchronous reset, active high
   input wire [7:0] reg_addr_in,        // Register address
   input wire [7:0] reg_wdata_in,       // Write data
   input wire reg_wr_in,                // Write strobe, one cycle
   input wire reg_rd_in,                // Read strobe, one cycle
   output reg [7:0] reg_rdata_out,      // Read data, valid cycle after strobe
   input wire [5:0] group_current_code_in, // Grouped backlight target code
   output reg [5:0] group_applied_code_out, // Ramped grouped code
   output wire ch4_group_select_out,    // Channel four joined to group
   output wire ch5_group_select_out,    // Channel five joined to group
   output reg [5:0] ch4_sink_code_out,  // Code applied to channel four
   output reg [5:0] ch5_sink_code_out,  // Code applied to channel five
   output wire [11:0] ch4_level_out,    // Square-law level, channel four
   output wire [11:0] ch5_level_out     // Square-law level, channel five
);

   localparam NCH = 2;

   reg ch4_group_select_q;
   reg ch5_group_select_q;
   reg [5:0] ch4_current_code_q;
   reg [5:0] ch5_current_code_q;
   reg [3:0] group_fade_out_time_q;
   reg [3:0] group_fade_in_time_q;
   reg [31:0] step_cnt_q;
   reg [7:0] rdata_d;
   reg ch4_group_select_d;
   reg ch5_group_select_d;
   reg [5:0] ch4_current_code_d;
   reg [5:0] ch5_current_code_d;
   reg [3:0] group_fade_out_time_d;
   reg [3:0] group_fade_in_time_d;
   reg [5:0] applied_d;
   reg [31:0] step_cnt_d;

   wire ramp_up;
   wire ramp_down;
   wire [3:0] fade_code;
   wire [31:0] step_interval;
   wire [NCH*6-1:0] eff_codes;
   wire [NCH*12-1:0] levels;
   wire [NCH-1:0] grouped;
   wire [NCH*6-1:0] own_codes;
   wire wr_ch4;
   wire wr_ch5;
   wire wr_fade;
   wire step_done;

   function sel_hit;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         sel_hit = (addr == ofs);
      end
   endfunction

   // Write decode, one hit per mapped offset
   assign wr_ch4 = reg_wr_in && sel_hit(reg_addr_in, `CH4_SINK_CONFIG_OFS);
   assign wr_ch5 = reg_wr_in && sel_hit(reg_addr_in, `CH5_SINK_CONFIG_OFS);
   assign wr_fade = reg_wr_in && sel_hit(reg_addr_in, `GROUP_FADE_TIMING_OFS);

   // Register next values; unused bit 6 of the sink rows is simply never stored
   always @* begin
      ch4_group_select_d = ch4_group_select_q;
      ch5_group_select_d = ch5_group_select_q;
      ch4_current_code_d = ch4_current_code_q;
      ch5_current_code_d = ch5_current_code_q;
      group_fade_out_time_d = group_fade_out_time_q;
      group_fade_in_time_d = group_fade_in_time_q;
      if (wr_ch4) begin
         ch4_group_select_d = reg_wdata_in[`GROUP_SELECT_BIT];
         ch4_current_code_d = reg_wdata_in[`CODE_MSB:`CODE_LSB];
      end
      if (wr_ch5) begin
         ch5_group_select_d = reg_wdata_in[`GROUP_SELECT_BIT];
         ch5_current_code_d = reg_wdata_in[`CODE_MSB:`CODE_LSB];
      end
      if (wr_fade) begin
         group_fade_out_time_d = reg_wdata_in[`FADE_OUT_MSB:`FADE_OUT_LSB];
         group_fade_in_time_d = reg_wdata_in[`FADE_IN_MSB:`FADE_IN_LSB];
      end
   end

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ch4_group_select_q <= `GROUP_SELECT_RST;
         ch5_group_select_q <= `GROUP_SELECT_RST;
         ch4_current_code_q <= `CURRENT_CODE_RST;
         ch5_current_code_q <= `CURRENT_CODE_RST;
         group_fade_out_time_q <= `FADE_TIME_RST;
         group_fade_in_time_q <= `FADE_TIME_RST;
      end else begin
         ch4_group_select_q <= ch4_group_select_d;
         ch5_group_select_q <= ch5_group_select_d;
         ch4_current_code_q <= ch4_current_code_d;
         ch5_current_code_q <= ch5_current_code_d;
         group_fade_out_time_q <= group_fade_out_time_d;
         group_fade_in_time_q <= group_fade_in_time_d;
      end
   end

   // Read mux; unused bit 6 and unmapped addresses read zero
   always @* begin
      rdata_d = `UNMAPPED_READ;
      if (sel_hit(reg_addr_in, `CH4_SINK_CONFIG_OFS)) begin
         rdata_d = {ch4_group_select_q, 1'b0, ch4_current_code_q};
      end else if (sel_hit(reg_addr_in, `CH5_SINK_CONFIG_OFS)) begin
         rdata_d = {ch5_group_select_q, 1'b0, ch5_current_code_q};
      end else if (sel_hit(reg_addr_in, `GROUP_FADE_TIMING_OFS)) begin
         rdata_d = {group_fade_out_time_q, group_fade_in_time_q};
      end
   end

   // Held until the next read strobe so a slow master can sample it
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rdata_d;
      end
   end

   // Fade ramp: direction picks the time field, step period is time / 63
   assign ramp_up = (group_current_code_in > group_applied_code_out);
   assign ramp_down = (group_current_code_in < group_applied_code_out);
   assign fade_code = ramp_up ? group_fade_in_time_q : group_fade_out_time_q;
   assign step_interval = STEP_UNIT_CYCLES * fade_code;
   assign step_done = (step_cnt_q >= step_interval - 32'h0000_0001);

   // Fixed per-step period makes partial ramps finish proportionally sooner
   always @* begin
      applied_d = group_applied_code_out;
      step_cnt_d = step_cnt_q + 32'h0000_0001;
      if (!ramp_up && !ramp_down) begin
         // At target: the next ramp starts on a fresh period
         step_cnt_d = 32'h0000_0000;
      end else if (fade_code == 4'h0) begin
         // Fading disabled: jump straight to target
         applied_d = group_current_code_in;
         step_cnt_d = 32'h0000_0000;
      end else if (step_done) begin
         // Count kept on a reversal, so its first step may come early
         step_cnt_d = 32'h0000_0000;
         if (ramp_up) begin
            applied_d = group_applied_code_out + 6'h01;
         end else begin
            applied_d = group_applied_code_out - 6'h01;
         end
      end
   end

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         group_applied_code_out <= `CURRENT_CODE_RST;
         step_cnt_q <= 32'h0000_0000;
      end else begin
         group_applied_code_out <= applied_d;
         step_cnt_q <= step_cnt_d;
      end
   end

   assign ch4_group_select_out = ch4_group_select_q;
   assign ch5_group_select_out = ch5_group_select_q;
   assign grouped = {ch5_group_select_q, ch4_group_select_q};
   assign own_codes = {ch5_current_code_q, ch4_current_code_q};

   // Per-channel source select and square-law level
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
         // Own code ignored while the channel follows the group
         assign eff_codes[gi*6 +: 6] = grouped[gi] ? group_applied_code_out
                                                   : own_codes[gi*6 +: 6];
         sink_level_map u_map (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .code_in(eff_codes[gi*6 +: 6]),
            .level_out(levels[gi*12 +: 12])
         );
      end
   endgenerate

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ch4_sink_code_out <= `CURRENT_CODE_RST;
         ch5_sink_code_out <= `CURRENT_CODE_RST;
      end else begin
         ch4_sink_code_out <= eff_codes[5:0];
         ch5_sink_code_out <= eff_codes[11:6];
      end
   end

   assign ch4_level_out = levels[11:0];
   assign ch5_level_out = levels[23:12];

endmodule // led_sink_config_fade_timer

/* File: tb/led_sink_chk.sv */
// Checker for the channel four/five sink registers and grouped fade ramp.
// Assumes it is bound to the top module; one clock domain.
`timescale 1ns/1ns
module led_sink_chk (
   input wire clk_in, input wire rst_in, input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in, input wire reg_wr_in, input wire reg_rd_in,
   input wire [7:0] reg_rdata_out, input wire [5:0] group_current_code_in,
   input wire [5:0] group_applied_code_out, input wire ch4_group_select_out,
   input wire ch5_group_select_out, input wire [5:0] ch4_sink_code_out,
   input wire [5:0] ch5_sink_code_out, input wire [11:0] ch4_level_out,
   input wire [11:0] ch5_level_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   wire w4 = reg_wr_in && reg_addr_in == 8'h2b;
   wire w5 = reg_wr_in && reg_addr_in == 8'h2c;
   AST_CH4_SEL: assert property (w4 |=> ch4_group_select_out == $past(reg_wdata_in[7]))
      else $error("ch4 select wrong");
   AST_CH5_SEL: assert property (w5 |=> ch5_group_select_out == $past(reg_wdata_in[7]))
      else $error("ch5 select wrong");
   AST_CH4_OWN: assert property ((w4 && !reg_wdata_in[7]) ##1 !w4 |=>
      ch4_sink_code_out == $past(reg_wdata_in[5:0], 2)) else $error("ch4 own code wrong");
   AST_CH4_GRP: assert property (ch4_group_select_out |=>
      ch4_sink_code_out == $past(group_applied_code_out)) else $error("ch4 group code wrong");
   AST_CH5_GRP: assert property (ch5_group_select_out |=>
      ch5_sink_code_out == $past(group_applied_code_out)) else $error("ch5 group code wrong");
   AST_BIT6: assert property ((reg_rd_in && (w4 || w5 || reg_addr_in == 8'h2b || reg_addr_in == 8'h2c)) |=> !reg_rdata_out[6])
      else $error("unused bit set");
   AST_STEP: assert property ($changed(group_applied_code_out) |->
      group_applied_code_out == $past(group_current_code_in) ||
      ($past(group_current_code_in) > $past(group_applied_code_out) ?
      group_applied_code_out == $past(group_applied_code_out) + 6'h1 :
      group_applied_code_out == $past(group_applied_code_out) - 6'h1)) else $error("bad step");
   AST_HOLD: assert property ($stable(group_current_code_in) &&
      group_applied_code_out == group_current_code_in |=> $stable(group_applied_code_out))
      else $error("applied code moved at target");
   AST_LEVEL: assert property ($stable(ch4_sink_code_out) && $stable(ch5_sink_code_out) |->
      ch4_level_out == ch4_sink_code_out * ch4_sink_code_out &&
      ch5_level_out == ch5_sink_code_out * ch5_sink_code_out) else $error("level wrong");
   cover property (w4 && reg_wdata_in[7]);
   cover property ($changed(group_applied_code_out) && ch4_group_select_out);
   cover property (reg_rd_in && reg_addr_in == 8'h2d);
endmodule // led_sink_chk

/* File: tb/led_sink_config_fade_timer_bench.sv */
// Self-checking bench: register rows, reset values, fade ramp timing.
// Assumes a short ramp unit so that full ramps stay brief.
`timescale 1ns/1ns
module led_sink_config_fade_timer_bench;
   reg clk_in = 1'h0, rst_in = 1'h1, reg_wr_in = 1'h0, reg_rd_in = 1'h0;
   reg [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
   reg [5:0] group_current_code_in = 6'h00;
   wire [7:0] reg_rdata_out;
   wire [5:0] group_applied_code_out, ch4_sink_code_out, ch5_sink_code_out;
   wire ch4_group_select_out, ch5_group_select_out;
   wire [11:0] ch4_level_out, ch5_level_out;
   integer num_errors = 0, num_checks = 0, i, n;
   reg [23:0] rows [0:5];
   always #5 clk_in = ~clk_in;
   led_sink_config_fade_timer #(.STEP_UNIT_CYCLES(2)) uut (.clk_in(clk_in), .rst_in(rst_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .group_current_code_in(group_current_code_in),
      .group_applied_code_out(group_applied_code_out),
      .ch4_group_select_out(ch4_group_select_out), .ch5_group_select_out(ch5_group_select_out),
      .ch4_sink_code_out(ch4_sink_code_out), .ch5_sink_code_out(ch5_sink_code_out),
      .ch4_level_out(ch4_level_out), .ch5_level_out(ch5_level_out));
   task chk(input [11:0] got, input [11:0] exp); begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   end endtask
   task access(input w, input [7:0] a, input [7:0] d); begin
      @(negedge clk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = w;
      reg_rd_in = !w;
      @(negedge clk_in);
      reg_wr_in = 1'h0;
      reg_rd_in = 1'h0;
   end endtask
   // Edges taken from a new target until the applied code arrives
   task ramp(input [5:0] t, input [11:0] edges); begin
      @(negedge clk_in);
      group_current_code_in = t;
      n = 0;
      while (group_applied_code_out !== t && n < 100) begin
         @(negedge clk_in);
         n = n + 1;
      end
      chk(n[11:0], edges);
   end endtask
   task end_of_test; begin
      $display("Checks: %0d, errors: %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   end endtask
   initial begin
      rows[0] = 24'h2bffbf; rows[1] = 24'h2c7f3f; rows[2] = 24'h2da5a5;
      rows[3] = 24'h2e5a00; rows[4] = 24'h2b4a0a; rows[5] = 24'h2c8585;
      repeat (10) @(negedge clk_in);
      rst_in = 1'h0;
      for (i = 0; i < 6; i = i + 1) begin
         access(1'h1, rows[i][23:16], rows[i][15:8]);
         access(1'h0, rows[i][23:16], 8'h00);
         chk({4'h0, reg_rdata_out}, {4'h0, rows[i][7:0]});
      end
      chk(ch4_level_out, 12'h064);
      chk({6'h00, ch5_sink_code_out}, 12'h000);
      rst_in = 1'h1;
      repeat (3) @(negedge clk_in);
      rst_in = 1'h0;
      for (i = 0; i < 3; i = i + 1) begin
         access(1'h0, 8'h2b + i[7:0], 8'h00);
         chk({4'h0, reg_rdata_out}, 12'h000);
      end
      access(1'h1, 8'h2b, 8'h80);
      access(1'h1, 8'h2d, 8'h21);
      ramp(6'h03, 12'h006);
      ramp(6'h00, 12'h00c);
      access(1'h1, 8'h2d, 8'hf0);
      ramp(6'h3f, 12'h001);
      ramp(6'h3e, 12'h01e);
      access(1'h1, 8'h2d, 8'h0f);
      ramp(6'h00, 12'h001);
      ramp(6'h02, 12'h03c);
      repeat (3) @(negedge clk_in);
      chk(ch4_level_out, 12'h004);
      access(1'h1, 8'h2c, 8'h3f);
      repeat (2) @(negedge clk_in);
      chk({11'h000, ch4_group_select_out}, 12'h001);
      chk({11'h000, ch5_group_select_out}, 12'h000);
      chk({6'h00, ch4_sink_code_out}, 12'h002);
      chk(ch5_level_out, 12'hf81);
      end_of_test;
   end
endmodule // led_sink_config_fade_timer_bench
bind led_sink_config_fade_timer led_sink_chk chk_i (.clk_in(clk_in), .rst_in(rst_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .group_current_code_in(group_current_code_in), .group_applied_code_out(group_applied_code_out),
   .ch4_group_select_out(ch4_group_select_out), .ch5_group_select_out(ch5_group_select_out),
   .ch4_sink_code_out(ch4_sink_code_out), .ch5_sink_code_out(ch5_sink_code_out),
   .ch4_level_out(ch4_level_out), .ch5_level_out(ch5_level_out));
